// file: verilog/rcb_pkg.sv
// register map, field positions, states and carrier types of the repeater control bank
`default_nettype none
package rcb_pkg;
    localparam logic [7:0] OFS_STRAP = 8'h00;
    localparam logic [7:0] OFS_PDN = 8'h01;
    localparam logic [7:0] OFS_OVR = 8'h02;
    localparam logic [7:0] OFS_RSV3 = 8'h03;
    localparam logic [7:0] OFS_RSV4 = 8'h04;
    localparam logic [7:0] OFS_RSV5 = 8'h05;
    localparam logic [7:0] OFS_CTL = 8'h06;
    localparam logic [7:0] OFS_DRST = 8'h07;
    localparam logic [7:0] RST_STRAP = 8'h00;
    localparam logic [7:0] RST_PDN = 8'h00;
    localparam logic [7:0] RST_OVR = 8'h00;
    localparam logic [7:0] RST_RSV = 8'h00;
    localparam logic [7:0] RST_CTL = 8'h10;
    localparam logic [7:0] RST_DRST = 8'h01;
    localparam int STRAP_MSB = 6;
    localparam int STRAP_LSB = 3;
    localparam int LOAD_DONE_BIT = 2;
    localparam int OVR_PIN_BIT = 0;
    localparam int CTL_EN_BIT = 3;
    localparam int REG_RST_BIT = 6;
    localparam int MST_RST_BIT = 5;
    localparam int STRAP_W = 4;
    localparam int NUM_CHAN = 8;
    localparam logic [7:0] SLAVE_BASE = 8'hb0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] REG_RST_CYCLES = 3'h1;
    localparam logic [2:0] LOADER_RST_CYCLES = 3'h4;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_REG = 3'b011,
        ST_ACK_REG = 3'b100,
        ST_DATA = 3'b101,
        ST_ACK_DATA = 3'b110,
        ST_TX = 3'b111
    } rcb_bus_state_type;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } rcb_edge_type;

    typedef struct packed {
        logic prev;
    } rcb_edge_state_type;

    typedef struct packed {
        logic [2:0] cnt;
        logic act;
    } rcb_clr_state_type;

    typedef struct packed {
        rcb_bus_state_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic oe;
        logic sda_low;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] r3;
        logic [7:0] r4;
        logic [7:0] r5;
        logic [7:0] r6;
        logic [7:0] r7;
        logic [7:0] chan_dis;
        logic ctl_en;
    } rcb_main_state_type;
endpackage
`default_nettype wire

// file: verilog/rcb_edge_track.sv
// edge tracker for one bus line
`timescale 1ns/10ps
`default_nettype none
module rcb_edge_track #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic line_in,
    output var rcb_pkg::rcb_edge_type edge_out
);
    rcb_pkg::rcb_edge_state_type state_reg;
    rcb_pkg::rcb_edge_state_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.prev = line_in;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '{prev: IDLE_LEVEL};
        end else begin
            state_reg <= state_next;
        end
    end

    // idle level at reset keeps a released bus from faking an edge
    assign edge_out = '{level: line_in, rise: line_in & ~state_reg.prev,
                        fall: ~line_in & state_reg.prev};
endmodule
`default_nettype wire

// file: verilog/rcb_self_clear.sv
// self-clearing control bit that holds for a set number of cycles
`timescale 1ns/10ps
`default_nettype none
module rcb_self_clear #(
    parameter logic [2:0] HOLD = 3'h1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set,
    output logic active
);
    rcb_pkg::rcb_clr_state_type state_reg;
    rcb_pkg::rcb_clr_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (set) begin
            state_next.cnt = HOLD;
        end else if (state_reg.cnt != 3'h0) begin
            state_next.cnt = state_reg.cnt - 3'h1;
        end
        state_next.act = (state_next.cnt != 3'h0);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '{cnt: 3'h0, act: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign active = state_reg.act;
endmodule
`default_nettype wire

// file: verilog/rcb_reg_bank.sv
// smbus slave and low control registers of the eight-channel repeater
`timescale 1ns/10ps
`default_nettype none
module rcb_reg_bank (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic serial_management_select_pin,
    input wire logic [3:0] addr_strap,
    input wire logic eeprom_load_done,
    input wire logic channel_power_down_pin,
    output logic [7:0] channel_disable,
    output logic smbus_control_enable,
    output logic loader_reset
);
    rcb_pkg::rcb_main_state_type state_reg;
    rcb_pkg::rcb_main_state_type state_next;
    rcb_pkg::rcb_edge_type scl_e;
    rcb_pkg::rcb_edge_type sda_e;
    logic start_det;
    logic stop_det;
    logic wr_en;
    logic reg_active;
    logic [7:0] rd_byte;
    logic [7:0] addr_match;

    rcb_edge_track #(.IDLE_LEVEL(1'b1)) u_scl (
        .clk(clk),
        .nrst(nrst),
        .line_in(scl_in),
        .edge_out(scl_e)
    );

    rcb_edge_track #(.IDLE_LEVEL(1'b1)) u_sda (
        .clk(clk),
        .nrst(nrst),
        .line_in(sda_in),
        .edge_out(sda_e)
    );

    // a self-clearing bit reads back as its own active flag
    rcb_self_clear #(.HOLD(rcb_pkg::REG_RST_CYCLES)) u_reg_rst (
        .clk(clk),
        .nrst(nrst),
        .set(wr_en && state_reg.ptr == rcb_pkg::OFS_DRST && state_reg.sh[rcb_pkg::REG_RST_BIT]),
        .active(reg_active)
    );

    rcb_self_clear #(.HOLD(rcb_pkg::LOADER_RST_CYCLES)) u_mst_rst (
        .clk(clk),
        .nrst(nrst),
        .set(wr_en && state_reg.ptr == rcb_pkg::OFS_DRST && state_reg.sh[rcb_pkg::MST_RST_BIT]),
        .active(loader_reset)
    );

    // scl high on the current sample alone qualifies an sda edge as start or stop
    assign start_det = sda_e.fall && scl_e.level;
    assign stop_det = sda_e.rise && scl_e.level;
    assign addr_match = rcb_pkg::SLAVE_BASE + {3'h0, addr_strap, 1'b0};

    always_comb begin
        rd_byte = rcb_pkg::UNMAPPED_READ;
        unique case (state_reg.ptr)
            rcb_pkg::OFS_STRAP: begin
                rd_byte = {state_reg.r0[7], addr_strap, eeprom_load_done, state_reg.r0[1:0]};
            end
            rcb_pkg::OFS_PDN: rd_byte = state_reg.r1;
            rcb_pkg::OFS_OVR: rd_byte = state_reg.r2;
            rcb_pkg::OFS_RSV3: rd_byte = state_reg.r3;
            rcb_pkg::OFS_RSV4: rd_byte = state_reg.r4;
            rcb_pkg::OFS_RSV5: rd_byte = state_reg.r5;
            rcb_pkg::OFS_CTL: rd_byte = state_reg.r6;
            rcb_pkg::OFS_DRST: begin
                rd_byte = {state_reg.r7[7], reg_active, loader_reset, state_reg.r7[4:0]};
            end
            default: rd_byte = rcb_pkg::UNMAPPED_READ;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.sda_low = 1'b0;
        wr_en = 1'b0;
        if (!serial_management_select_pin) begin
            state_next.st = rcb_pkg::ST_IDLE;
            state_next.oe = 1'b0;
        end else if (start_det) begin
            // repeated start lands here too, keeping the pointer
            state_next.st = rcb_pkg::ST_ADDR;
            state_next.cnt = 4'h0;
            state_next.oe = 1'b0;
        end else if (stop_det) begin
            state_next.st = rcb_pkg::ST_IDLE;
            state_next.oe = 1'b0;
        end else begin
            if (scl_e.rise && state_reg.st inside {rcb_pkg::ST_ADDR, rcb_pkg::ST_REG,
                                                   rcb_pkg::ST_DATA, rcb_pkg::ST_TX}) begin
                state_next.cnt = state_reg.cnt + 4'h1;
                if (state_reg.st != rcb_pkg::ST_TX) begin
                    state_next.sh = {state_reg.sh[6:0], sda_e.level};
                end
            end
            if (scl_e.fall) begin
                unique case (state_reg.st)
                    rcb_pkg::ST_IDLE: begin
                    end
                    rcb_pkg::ST_ADDR: begin
                        if (state_reg.cnt == rcb_pkg::BYTE_BITS) begin
                            state_next.cnt = 4'h0;
                            if (state_reg.sh[7:1] == addr_match[7:1]) begin
                                state_next.oe = 1'b1;
                                state_next.rw = state_reg.sh[0];
                                state_next.st = rcb_pkg::ST_ACK_ADDR;
                            end else begin
                                state_next.st = rcb_pkg::ST_IDLE;
                            end
                        end
                    end
                    rcb_pkg::ST_ACK_ADDR: begin
                        if (state_reg.rw) begin
                            state_next.sh = rd_byte;
                            state_next.oe = ~rd_byte[7];
                            state_next.st = rcb_pkg::ST_TX;
                        end else begin
                            state_next.oe = 1'b0;
                            state_next.st = rcb_pkg::ST_REG;
                        end
                    end
                    rcb_pkg::ST_REG: begin
                        if (state_reg.cnt == rcb_pkg::BYTE_BITS) begin
                            state_next.cnt = 4'h0;
                            state_next.ptr = state_reg.sh;
                            state_next.oe = 1'b1;
                            state_next.st = rcb_pkg::ST_ACK_REG;
                        end
                    end
                    rcb_pkg::ST_ACK_REG: begin
                        state_next.oe = 1'b0;
                        state_next.st = rcb_pkg::ST_DATA;
                    end
                    rcb_pkg::ST_DATA: begin
                        if (state_reg.cnt == rcb_pkg::BYTE_BITS) begin
                            state_next.cnt = 4'h0;
                            wr_en = 1'b1;
                            state_next.oe = 1'b1;
                            state_next.st = rcb_pkg::ST_ACK_DATA;
                        end
                    end
                    rcb_pkg::ST_ACK_DATA: begin
                        // one byte per write; extra bytes go unanswered
                        state_next.oe = 1'b0;
                        state_next.st = rcb_pkg::ST_IDLE;
                    end
                    rcb_pkg::ST_TX: begin
                        if (state_reg.cnt == rcb_pkg::BYTE_BITS) begin
                            // the host ack or nack bit is left to the bus
                            state_next.cnt = 4'h0;
                            state_next.oe = 1'b0;
                            state_next.st = rcb_pkg::ST_IDLE;
                        end else begin
                            state_next.sh = {state_reg.sh[6:0], 1'b0};
                            state_next.oe = ~state_reg.sh[6];
                        end
                    end
                endcase
            end
        end
        // register reset wins over a bus write in the same cycle
        if (reg_active) begin
            state_next.r0 = rcb_pkg::RST_STRAP;
            state_next.r1 = rcb_pkg::RST_PDN;
            state_next.r2 = rcb_pkg::RST_OVR;
            state_next.r3 = rcb_pkg::RST_RSV;
            state_next.r4 = rcb_pkg::RST_RSV;
            state_next.r5 = rcb_pkg::RST_RSV;
            state_next.r6 = rcb_pkg::RST_CTL;
            state_next.r7 = rcb_pkg::RST_DRST;
        end else if (wr_en) begin
            unique case (state_reg.ptr)
                rcb_pkg::OFS_STRAP: state_next.r0 = state_reg.sh & 8'h83;
                rcb_pkg::OFS_PDN: state_next.r1 = state_reg.sh;
                rcb_pkg::OFS_OVR: state_next.r2 = state_reg.sh;
                rcb_pkg::OFS_RSV3: state_next.r3 = state_reg.sh;
                rcb_pkg::OFS_RSV4: state_next.r4 = state_reg.sh;
                rcb_pkg::OFS_RSV5: state_next.r5 = state_reg.sh;
                rcb_pkg::OFS_CTL: state_next.r6 = state_reg.sh;
                rcb_pkg::OFS_DRST: state_next.r7 = state_reg.sh & 8'h9f;
                default: begin
                end
            endcase
        end
        // pin acts only as an extra power-down, never re-enables a channel
        state_next.chan_dis = state_reg.r1 |
            (state_reg.r2[rcb_pkg::OVR_PIN_BIT] ? 8'h00 : {8{channel_power_down_pin}});
        state_next.ctl_en = state_reg.r6[rcb_pkg::CTL_EN_BIT];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '{st: rcb_pkg::ST_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
                           rw: 1'b0, oe: 1'b0, sda_low: 1'b0,
                           r0: rcb_pkg::RST_STRAP, r1: rcb_pkg::RST_PDN, r2: rcb_pkg::RST_OVR,
                           r3: rcb_pkg::RST_RSV, r4: rcb_pkg::RST_RSV, r5: rcb_pkg::RST_RSV,
                           r6: rcb_pkg::RST_CTL, r7: rcb_pkg::RST_DRST,
                           chan_dis: 8'h00, ctl_en: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sda_out = state_reg.sda_low;
    assign sda_oe = state_reg.oe;
    assign channel_disable = state_reg.chan_dis;
    assign smbus_control_enable = state_reg.ctl_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_reg_rst_req;
        wr_en && state_reg.ptr == rcb_pkg::OFS_DRST && state_reg.sh[6];
    endsequence

    sequence s_mst_rst_req;
        wr_en && state_reg.ptr == rcb_pkg::OFS_DRST && state_reg.sh[5];
    endsequence

    sequence s_addr_hit;
        serial_management_select_pin && scl_e.fall && state_reg.st == rcb_pkg::ST_ADDR &&
        state_reg.cnt == 4'h8 && state_reg.sh[7:1] == addr_match[7:1];
    endsequence

    sequence s_read_turn;
        serial_management_select_pin && scl_e.fall && state_reg.st == rcb_pkg::ST_ACK_ADDR &&
        state_reg.rw;
    endsequence

    a_strap_obs: assert property (
        state_reg.ptr == 8'h00 |-> rd_byte[6:3] == addr_strap)
        else $error("strap observation bits wrong");
    a_load_done: assert property (
        state_reg.ptr == 8'h00 |-> rd_byte[2] == eeprom_load_done)
        else $error("load done bit wrong");
    a_pdn_write: assert property (
        wr_en && state_reg.ptr == 8'h01 && !reg_active |=> state_reg.r1 == $past(state_reg.sh))
        else $error("power-down write lost");
    a_chan_disable: assert property (
        1'b1 |=> channel_disable == ($past(state_reg.r1) |
            ($past(state_reg.r2[0]) ? 8'h00 : {8{$past(channel_power_down_pin)}})))
        else $error("channel disable mismatch");
    a_pin_blocked: assert property (
        state_reg.r2[0] && channel_power_down_pin |=> channel_disable == $past(state_reg.r1))
        else $error("override did not block pin");
    a_ctl_enable: assert property (
        state_reg.r6[3] != smbus_control_enable |=> smbus_control_enable == $past(state_reg.r6[3]))
        else $error("control enable not following register");
    a_reg_reset: assert property (
        s_reg_rst_req |=> reg_active ##1 (!reg_active && state_reg.r1 == 8'h00 &&
            state_reg.r2 == 8'h00 && state_reg.r6 == 8'h10 && state_reg.r7 == 8'h01))
        else $error("register reset sequence wrong");
    a_loader_reset: assert property (
        s_mst_rst_req |=> loader_reset [*4] ##1 !loader_reset)
        else $error("loader reset pulse wrong");
    a_addr_ack: assert property (
        s_addr_hit |=> sda_oe && !sda_out && state_reg.st == rcb_pkg::ST_ACK_ADDR)
        else $error("address not acknowledged");
    a_stop_release: assert property (
        stop_det && !start_det |=> !sda_oe && state_reg.st == rcb_pkg::ST_IDLE)
        else $error("bus not released at stop");
    a_status_readonly: assert property (
        wr_en && state_reg.ptr == rcb_pkg::OFS_STRAP && !reg_active |=> state_reg.r0[6:2] == 5'h00)
        else $error("read-only status bits stored");
    a_read_first_bit: assert property (
        s_read_turn |=> state_reg.st == rcb_pkg::ST_TX && sda_oe == !$past(rd_byte[7]))
        else $error("first read bit wrong");
    a_reg_ptr_ack: assert property (
        serial_management_select_pin && scl_e.fall && state_reg.st == rcb_pkg::ST_REG &&
        state_reg.cnt == 4'h8 |=> sda_oe && state_reg.ptr == $past(state_reg.sh))
        else $error("register byte not taken");
    a_data_ack: assert property (
        serial_management_select_pin && scl_e.fall && state_reg.st == rcb_pkg::ST_DATA &&
        state_reg.cnt == 4'h8 |=> sda_oe && state_reg.st == rcb_pkg::ST_ACK_DATA)
        else $error("data byte not acknowledged");
    a_deselect_idle: assert property (
        !serial_management_select_pin |=> !sda_oe && state_reg.st == rcb_pkg::ST_IDLE)
        else $error("deselected slave still active");
endmodule
`default_nettype wire

// file: bench/rcb_host_model.sv
// smbus host model driving the bus clock and the open-drain data line
`timescale 1ns/10ps
`default_nettype none
module rcb_host_model (
    input wire logic clk,
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output wire logic sda
);
    logic drv;
    // pull-up: line is high unless a party pulls it low
    assign sda = drv & ~(sda_oe & ~sda_out);
    initial begin
        scl = 1'b1;
        drv = 1'b1;
    end
    // four core clocks a phase keeps every bus edge well apart
    task automatic half;
        repeat (4) @(negedge clk);
    endtask
    task automatic start;
        drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        drv = 1'b0;
        half();
        scl = 1'b0;
        half();
    endtask
    task automatic stop;
        drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        drv = 1'b1;
        half();
    endtask
    // one bit slot; returns the line level seen while scl is high
    task automatic slot(input logic b, output logic seen);
        drv = b;
        half();
        scl = 1'b1;
        half();
        seen = sda;
        scl = 1'b0;
        half();
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(b[i], s);
        end
        slot(1'b1, s);
        ack = ~s;
    endtask
    task automatic write_reg(input logic [7:0] adr, input logic [7:0] ofs,
                             input logic [7:0] d, output logic [2:0] ack);
        start();
        send_byte(adr, ack[2]);
        send_byte(ofs, ack[1]);
        send_byte(d, ack[0]);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] adr, input logic [7:0] ofs,
                            output logic [7:0] d, output logic [2:0] ack);
        logic s;
        start();
        send_byte(adr, ack[2]);
        send_byte(ofs, ack[1]);
        start();
        send_byte(adr | 8'h01, ack[0]);
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, d[i]);
        end
        // host nack ends the read
        slot(1'b1, s);
        stop();
    endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the repeater control register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk;
    logic nrst;
    logic scl;
    wire logic sda;
    logic sda_out;
    logic sda_oe;
    logic sel;
    logic [3:0] strap;
    logic done;
    logic pin;
    logic [7:0] chan_dis;
    logic ctl_en;
    logic ldr_rst;
    logic [7:0] rd;
    logic [2:0] ack;
    logic [7:0] adr;
    int ldr_cnt = 0;
    int failures;
    int checked;

    rcb_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
    rcb_reg_bank uut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .serial_management_select_pin(sel),
        .addr_strap(strap), .eeprom_load_done(done), .channel_power_down_pin(pin),
        .channel_disable(chan_dis), .smbus_control_enable(ctl_en),
        .loader_reset(ldr_rst));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ldr_rst === 1'b1) begin
            ldr_cnt++;
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host.write_reg(adr, ofs, d, ack);
        check("write ack", {5'h00, ack}, 8'h07);
    endtask
    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        host.read_reg(adr, ofs, rd, ack);
        check("read ack", {5'h00, ack}, 8'h07);
        check("read data", rd, exp);
    endtask
    task automatic conclude;
        $display("comparisons %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        // about three times the expected run
        #150000;
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        checked = 0;
        nrst = 1'b0;
        sel = 1'b1;
        strap = 4'h5;
        done = 1'b1;
        pin = 1'b0;
        adr = 8'hba;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check("oe idle", {7'h00, sda_oe}, 8'h00);
        check("sda out level", {7'h00, sda_out}, 8'h00);
        check("ctl en reset", {7'h00, ctl_en}, 8'h00);
        // defaults of the control registers
        rd_chk(rcb_pkg::OFS_PDN, 8'h00);
        rd_chk(rcb_pkg::OFS_OVR, 8'h00);
        rd_chk(rcb_pkg::OFS_CTL, 8'h10);
        rd_chk(rcb_pkg::OFS_DRST, 8'h01);
        // strap and load status, writes to the read-only bits dropped
        wr(rcb_pkg::OFS_STRAP, 8'h7c);
        rd_chk(rcb_pkg::OFS_STRAP, 8'h2c);
        strap = 4'ha;
        done = 1'b0;
        host.write_reg(8'hba, rcb_pkg::OFS_PDN, 8'hff, ack);
        check("stale address ack", {5'h00, ack}, 8'h00);
        adr = 8'hc4;
        rd_chk(rcb_pkg::OFS_STRAP, 8'h50);
        // power-down register, pin and override
        check("no stray write", chan_dis, 8'h00);
        wr(rcb_pkg::OFS_PDN, 8'ha5);
        check("chan dis reg", chan_dis, 8'ha5);
        pin = 1'b1;
        repeat (3) @(negedge clk);
        check("chan dis pin", chan_dis, 8'hff);
        wr(rcb_pkg::OFS_OVR, 8'h01);
        check("chan dis blocked", chan_dis, 8'ha5);
        wr(rcb_pkg::OFS_PDN, 8'hff);
        check("chan dis all", chan_dis, 8'hff);
        rd_chk(rcb_pkg::OFS_PDN, 8'hff);
        wr(rcb_pkg::OFS_PDN, 8'h00);
        check("chan dis none", chan_dis, 8'h00);
        wr(rcb_pkg::OFS_OVR, 8'h00);
        check("chan dis pin back", chan_dis, 8'hff);
        pin = 1'b0;
        // bus grant of channel settings; host keeps bit 4 set
        wr(rcb_pkg::OFS_CTL, 8'h18);
        check("ctl en on", {7'h00, ctl_en}, 8'h01);
        rd_chk(rcb_pkg::OFS_CTL, 8'h18);
        // loader reset pulse, low bits written as 0 0001
        wr(rcb_pkg::OFS_DRST, 8'h21);
        check("loader reset cycles", ldr_cnt[7:0], 8'h04);
        rd_chk(rcb_pkg::OFS_DRST, 8'h01);
        // register reset restores every default
        wr(rcb_pkg::OFS_PDN, 8'h3c);
        wr(rcb_pkg::OFS_DRST, 8'h41);
        rd_chk(rcb_pkg::OFS_DRST, 8'h01);
        rd_chk(rcb_pkg::OFS_PDN, 8'h00);
        rd_chk(rcb_pkg::OFS_CTL, 8'h10);
        check("ctl en after reset", {7'h00, ctl_en}, 8'h00);
        check("chan dis after reset", chan_dis, 8'h00);
        // unmapped offset is acked and reads zero
        wr(8'h09, 8'h55);
        rd_chk(8'h09, 8'h00);
        // deselected slave ignores the bus
        sel = 1'b0;
        host.write_reg(adr, rcb_pkg::OFS_PDN, 8'hff, ack);
        check("deselect ack", {5'h00, ack}, 8'h00);
        check("deselect write", chan_dis, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
